// *** hw/ali_map.vh ***
// Constants of the accelerometer loop interrogator.
// Assumes a 20 MHz mclk; all pulse trains arrive from the guidance computer.
`ifndef ALI_MAP_VH
`define ALI_MAP_VH
`define ALI_CLK_HZ 20000000
`define ALI_SAMPLE_RATE_PPS 3200
`define ALI_PERIOD_CYC (`ALI_CLK_HZ / `ALI_SAMPLE_RATE_PPS)
`define ALI_STROBE_NS 2000
`define ALI_STROBE_MIN_CYC ((`ALI_STROBE_NS * 20 + 999) / 1000)
`define ALI_HALF_CYCLE_PULSES 3
`define ALI_DIR_POS 1'b1
`define ALI_DIR_NEG 1'b0
`define ALI_TORQ_RST 1'b1
`define ALI_CNT_W 13
`endif

// *** hw/ali_sync.v ***
// Two-stage synchroniser for one pulse or phase input of the interrogator.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/10ps
module ali_sync (
  input wire mclk,
  input wire rstn,
  input wire din,
  output wire dout
);
  reg meta_ff;
  reg sync_ff;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule

// *** hw/ali_edge.v ***
// Rising-edge detector on a synchronised level.
// Assumes the input already passed a synchroniser.
`timescale 1ns/10ps
module ali_edge (
  input wire mclk,
  input wire rstn,
  input wire din,
  output wire rise
);
  reg last_ff;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= din;
    end
  end
  assign rise = din & ~last_ff;
endmodule

// *** hw/ali_interrogator.v ***
// Accelerometer loop interrogator and binary torque current switch logic.
// Assumes strobe, switch and data pulse trains arrive from the guidance computer.
`timescale 1ns/10ps
`include "ali_map.vh"

module ali_interrogator (
  input wire mclk,
  input wire rstn,
  input wire sample_strobe,
  input wire phase_zero,
  input wire phase_pi,
  input wire switch_pulse,
  input wire data_pulse,
  output reg positive_torque_set_pulse,
  output reg negative_torque_set_pulse,
  output reg pos_current_en,
  output reg neg_current_en,
  output reg pos_velocity_pulse,
  output reg neg_velocity_pulse,
  output reg loop_armed,
  output reg [`ALI_CNT_W-1:0] pos_run_len,
  output reg [`ALI_CNT_W-1:0] neg_run_len
);
  wire strobe_s;
  wire zero_s;
  wire pi_s;
  wire switch_s;
  wire data_s;
  wire switch_rise;
  wire data_rise;
  wire set_gate;
  wire rst_gate;
  reg sample_dir_ff;
  reg nxt_sample_dir;
  reg armed_ff;
  reg nxt_armed;
  reg torq_dir_ff;
  reg nxt_torq_dir;
  reg [`ALI_CNT_W-1:0] run_ff;
  reg [`ALI_CNT_W-1:0] nxt_run;

  function [`ALI_CNT_W-1:0] sat_inc;
    input [`ALI_CNT_W-1:0] v;
    begin
      if (&v) begin
        sat_inc = v;
      end else begin
        sat_inc = v + {{(`ALI_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Every pulse and phase pin crosses two flip-flops; phase inputs are sampled, not edge-detected.
  ali_sync u_sync_strobe (.mclk(mclk), .rstn(rstn), .din(sample_strobe), .dout(strobe_s));
  ali_sync u_sync_zero (.mclk(mclk), .rstn(rstn), .din(phase_zero), .dout(zero_s));
  ali_sync u_sync_pi (.mclk(mclk), .rstn(rstn), .din(phase_pi), .dout(pi_s));
  ali_sync u_sync_switch (.mclk(mclk), .rstn(rstn), .din(switch_pulse), .dout(switch_s));
  ali_sync u_sync_data (.mclk(mclk), .rstn(rstn), .din(data_pulse), .dout(data_s));
  ali_edge u_edge_switch (.mclk(mclk), .rstn(rstn), .din(switch_s), .rise(switch_rise));
  ali_edge u_edge_data (.mclk(mclk), .rstn(rstn), .din(data_s), .rise(data_rise));

  // Both phases at once is an amplifier fault; neither gate fires then, so
  // set and reset can never act in the same cycle.
  assign set_gate = strobe_s & zero_s & ~pi_s;
  assign rst_gate = strobe_s & pi_s & ~zero_s;

  // Sampling flip-flop.
  always @* begin
    nxt_sample_dir = sample_dir_ff;
    nxt_armed = armed_ff;
    if (set_gate) begin
      nxt_sample_dir = `ALI_DIR_POS;
      nxt_armed = 1'b1;
    end else if (rst_gate) begin
      nxt_sample_dir = `ALI_DIR_NEG;
      nxt_armed = 1'b1;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sample_dir_ff <= `ALI_DIR_POS;
      armed_ff <= 1'b0;
    end else begin
      sample_dir_ff <= nxt_sample_dir;
      armed_ff <= nxt_armed;
    end
  end

  // Torque switch flip-flop follows the torque-set pulses only once armed, so
  // no winding choice is made from a guessed float side after power-up.
  wire take_switch;
  wire take_data;
  wire run_end;
  reg torq_live_ff;
  reg nxt_torq_live;
  reg nxt_loop_armed;
  reg nxt_pos_set;
  reg nxt_neg_set;
  reg nxt_pos_cur;
  reg nxt_neg_cur;
  reg nxt_pos_vel;
  reg nxt_neg_vel;
  reg [`ALI_CNT_W-1:0] nxt_pos_run;
  reg [`ALI_CNT_W-1:0] nxt_neg_run;

  // One output gate: a taken pulse passes only for the wanted direction.
  // Every set, enable and velocity gate of the block is this one, so no two can disagree on polarity.
  function dir_gate;
    input take;
    input dir;
    input want;
    begin
      dir_gate = take & (dir == want);
    end
  endfunction

  assign take_switch = switch_rise & armed_ff;
  // Velocity pulses wait for the first torque choice, so the computer never
  // counts a period in which neither winding was energised.
  assign take_data = data_rise & torq_live_ff;
  // The first taken switch pulse after arming only starts a run; it ends none.
  assign run_end = take_switch & torq_live_ff & (sample_dir_ff != torq_dir_ff);

  always @* begin
    nxt_torq_dir = torq_dir_ff;
    nxt_torq_live = torq_live_ff;
    if (take_switch) begin
      nxt_torq_dir = sample_dir_ff;
      nxt_torq_live = 1'b1;
    end
  end

  // The torque flip-flop resets positive but drives nothing until it takes a pulse.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      torq_dir_ff <= `ALI_TORQ_RST;
      torq_live_ff <= 1'b0;
    end else begin
      torq_dir_ff <= nxt_torq_dir;
      torq_live_ff <= nxt_torq_live;
    end
  end

  // Run length of the current winding in strobe periods, for observing the
  // three-and-three pattern; it saturates rather than wraps.
  always @* begin
    nxt_run = run_ff;
    if (take_switch) begin
      if (!torq_live_ff || run_end) begin
        nxt_run = {{(`ALI_CNT_W-1){1'b0}}, 1'b1};
      end else begin
        nxt_run = sat_inc(run_ff);
      end
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_ff <= {`ALI_CNT_W{1'b0}};
    end else begin
      run_ff <= nxt_run;
    end
  end

  // The arm flag leaves one clock late, in step with the other outputs.
  always @* begin
    nxt_loop_armed = armed_ff;
  end

  // Both set gates read one flip-flop bit, so they can never fire together.
  always @* begin
    nxt_pos_set = dir_gate(take_switch, sample_dir_ff, `ALI_DIR_POS);
  end

  always @* begin
    nxt_neg_set = dir_gate(take_switch, sample_dir_ff, `ALI_DIR_NEG);
  end

  // Enables come from the next torque state, so they move on the same edge as
  // the torque-set pulse that causes them and never before the first one.
  always @* begin
    nxt_pos_cur = dir_gate(nxt_torq_live, nxt_torq_dir, `ALI_DIR_POS);
  end

  always @* begin
    nxt_neg_cur = dir_gate(nxt_torq_live, nxt_torq_dir, `ALI_DIR_NEG);
  end

  always @* begin
    nxt_pos_vel = dir_gate(take_data, torq_dir_ff, `ALI_DIR_POS);
  end

  always @* begin
    nxt_neg_vel = dir_gate(take_data, torq_dir_ff, `ALI_DIR_NEG);
  end

  always @* begin
    nxt_pos_run = pos_run_len;
    nxt_neg_run = neg_run_len;
    if (run_end) begin
      if (torq_dir_ff == `ALI_DIR_POS) begin
        nxt_pos_run = run_ff;
      end else begin
        nxt_neg_run = run_ff;
      end
    end
  end

  // Every output leaves straight from its own flip-flop, so the current
  // switches and the computer never see a gate glitch.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      loop_armed <= 1'b0;
    end else begin
      loop_armed <= nxt_loop_armed;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      positive_torque_set_pulse <= 1'b0;
    end else begin
      positive_torque_set_pulse <= nxt_pos_set;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      negative_torque_set_pulse <= 1'b0;
    end else begin
      negative_torque_set_pulse <= nxt_neg_set;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_current_en <= 1'b0;
    end else begin
      pos_current_en <= nxt_pos_cur;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      neg_current_en <= 1'b0;
    end else begin
      neg_current_en <= nxt_neg_cur;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_velocity_pulse <= 1'b0;
    end else begin
      pos_velocity_pulse <= nxt_pos_vel;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      neg_velocity_pulse <= 1'b0;
    end else begin
      neg_velocity_pulse <= nxt_neg_vel;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_run_len <= {`ALI_CNT_W{1'b0}};
    end else begin
      pos_run_len <= nxt_pos_run;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      neg_run_len <= {`ALI_CNT_W{1'b0}};
    end else begin
      neg_run_len <= nxt_neg_run;
    end
  end
endmodule

// *** testbench/ali_chk_asserts.sv ***
// Checker on the interrogator outputs.
// Bound into the design top; one clock, async low reset.
`timescale 1ns/10ps
module ali_chk (
  input wire mclk, input wire rstn, input wire loop_armed, input wire pos_current_en,
  input wire neg_current_en, input wire pos_velocity_pulse, input wire neg_velocity_pulse,
  input wire positive_torque_set_pulse, input wire negative_torque_set_pulse);
  wire ps = positive_torque_set_pulse, ns = negative_torque_set_pulse, pe = pos_current_en;
  wire ne = neg_current_en, pv = pos_velocity_pulse, nv = neg_velocity_pulse;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_sx; !(ps && ns); endproperty
  a_sx: assert property (p_sx) else $error("both set pulses");
  property p_ex; !(pe && ne); endproperty
  a_ex: assert property (p_ex) else $error("both windings");
  property p_idle; !loop_armed |-> !pe && !ne; endproperty
  a_idle: assert property (p_idle) else $error("winding unarmed");
  property p_ps; ps |-> pe ##1 !ps; endproperty
  a_ps: assert property (p_ps) else $error("positive set");
  property p_ns; ns |-> ne ##1 !ns; endproperty
  a_ns: assert property (p_ns) else $error("negative set");
  property p_rise; $rose(pe) || $rose(ne) |-> ps || ns; endproperty
  a_rise: assert property (p_rise) else $error("winding moved alone");
  property p_pv; pv |-> pe && !nv ##1 !pv; endproperty
  a_pv: assert property (p_pv) else $error("positive velocity");
  property p_nv; nv |-> ne ##1 !nv; endproperty
  a_nv: assert property (p_nv) else $error("negative velocity");
endmodule
bind ali_interrogator ali_chk ali_chk_i (.*);

// *** testbench/ali_cmp_model.sv ***
// Computer model: strobe, switch and data trains, velocity counter.
// PER is shortened from the real period since the logic counts nothing long.
`timescale 1ns/10ps
module ali_cmp_model #(parameter integer PER = 400) (
  input wire mclk, input wire rstn, input wire pos_velocity_pulse,
  input wire neg_velocity_pulse, output wire sample_strobe, output wire switch_pulse,
  output wire data_pulse, output reg [31:0] acc);
  integer cnt;
  assign {sample_strobe, switch_pulse, data_pulse} =
    {cnt < 40, cnt >= 60 && cnt < 120, cnt >= 100 && cnt < 160};
  always @(posedge mclk or negedge rstn) begin
    cnt <= !rstn ? 0 : (cnt == PER - 1) ? 0 : cnt + 1;
    acc <= !rstn ? 0 : acc + pos_velocity_pulse - neg_velocity_pulse;
  end
endmodule

// *** testbench/ali_interrogator_test.sv ***
// Bench: the computer model makes pulse trains, the bench drives pickoff phases.
// Run lengths are expected in pulse periods.
`timescale 1ns/10ps
module ali_interrogator_test;
  reg mclk = 1'h0, rstn = 1'h0, phase_zero = 1'h0, phase_pi = 1'h0;
  wire sample_strobe, switch_pulse, data_pulse, loop_armed, pos_current_en, neg_current_en;
  wire positive_torque_set_pulse, negative_torque_set_pulse;
  wire pos_velocity_pulse, neg_velocity_pulse;
  wire [12:0] pos_run_len, neg_run_len;
  wire [31:0] acc;
  integer n_errors = 0, cmp_count = 0;
  always #25 mclk = ~mclk;
  ali_cmp_model ali_cmp_model_i (.*);
  ali_interrogator ali_interrogator_i (.*);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) $display("[ERR] %0s exp %0h got %0h", nm, e, g);
    n_errors = n_errors + (g !== e);
  endtask
  task per(input logic [1:0] ph, input integer n);
    repeat (n) begin
      @(posedge mclk);
      {phase_zero, phase_pi} <= ph;
      @(negedge data_pulse);
    end
  endtask
  task t_refuse;
    per(2'h3, 2);
    chk("arm", 1'h0, loop_armed);
    per(2'h2, 3);
    chk("pen", 1'h1, pos_current_en);
  endtask
  task t_loop;
    per(2'h1, 3);
    per(2'h2, 3);
    per(2'h1, 3);
    chk("runs", {13'h3, 13'h3}, {pos_run_len, neg_run_len});
    chk("net", 32'h0, acc);
  endtask
  task t_reset;
    rstn <= 1'h0;
    @(posedge mclk);
    chk("rst", 3'h0, {loop_armed, pos_current_en, neg_current_en});
    rstn <= 1'h1;
    per(2'h1, 1);
    chk("nen", 1'h1, neg_current_en);
  endtask
  task print_verdict;
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    t_refuse;
    t_loop;
    t_reset;
    print_verdict;
  end
  initial begin
    #1000000 n_errors = n_errors + 1;
    print_verdict;
  end
endmodule
